// >>> logic/cmp_ctrl_pkg.sv
// Purpose: Shared constants and types for the comparator control block.
// Assumes: Avalon-MM byte addresses, 32-bit data, register data in bits 7:0.
// Notes: Register byte address is four times the register index.
`default_nettype none
package cmp_ctrl_pkg;
    // Bus geometry
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    // Register indices
    localparam logic [7:0] CTL_IDX = 8'h9B;
    localparam logic [7:0] MODE_IDX = 8'h9D;
    localparam logic [7:0] MUX_IDX = 8'h9F;
    localparam logic [7:0] STAT_IDX = 8'hA0;
    localparam logic [7:0] MASK_IDX = 8'hA1;
    // Field positions in control, status, mask and mux
    localparam int unsigned EN_BIT = 7;
    localparam int unsigned OUT_BIT = 6;
    localparam int unsigned RISE_BIT = 5;
    localparam int unsigned FALL_BIT = 4;
    localparam int unsigned HYP_LSB = 2;
    localparam int unsigned HYN_LSB = 0;
    localparam int unsigned NEG_SEL_LSB = 4;
    localparam int unsigned POS_SEL_LSB = 0;
    // Reset values
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [1:0] MODE_RST = 2'h2;
    localparam logic [7:0] MUX_RST = 8'hFF;
    localparam logic [1:0] MASK_RST = 2'h0;
    // Synchroniser depth
    localparam int unsigned SYNC_STAGES = 2;
    // Hysteresis amount codes
    typedef enum logic [1:0] {
        HYST_OFF = 2'h0,
        HYST_5MV = 2'h1,
        HYST_10MV = 2'h2,
        HYST_20MV = 2'h3
    } hyst_type;
    // Bus answer states
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_type;
endpackage
`default_nettype wire

// >>> logic/sync_if.sv
// Purpose: Carries one level into and out of a synchroniser.
// Assumes: Single clock domain on the output side.
// Notes: d may change at any time.
`default_nettype none
interface sync_if;
    logic d; // Asynchronous level in
    logic q; // Synchronised level out
    modport src (output d, input q);
    modport dst (input d, output q);
endinterface
`default_nettype wire

// >>> logic/cmp_sync.sv
// Purpose: Two-flop synchroniser for the raw comparator level.
// Assumes: Input comes from the asynchronous analog core.
// Notes: First stage is read only by the second.
`default_nettype none
module cmp_sync #(
    parameter int unsigned STAGES = 2
) (
    input wire logic clock,
    input wire logic rst_n,
    sync_if.dst s
);
    // Shift chain, oldest stage at the top
    logic [STAGES-1:0] chain_r;

    // Shift the level through the chain
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            chain_r <= '0;
        end else begin
            chain_r <= {chain_r[STAGES-2:0], s.d};
        end
    end

    assign s.q = chain_r[STAGES-1];
endmodule // cmp_sync
`default_nettype wire

// >>> logic/cmp_ctrl.sv
// Purpose: Control, edge flags and interrupt for an on-chip voltage comparator.
// Assumes: Avalon-MM slave with waitrequest; raw comparator result is asynchronous.
// Notes: Every access answers one cycle after it is first seen.
`default_nettype none
// Operation
// - Enable bit 7 powers the comparator
// - Result bit always shows comparator output
// - Falling edge sets fall flag bit 4
// - Rising edge sets rise flag bit 5
// - Flags stay set until software clears
// - Rise interrupt only with rise mask
// - Fall interrupt only with fall mask
// - Disabled comparator drives pin outputs low
// - Latched and raw outputs both provided
// - Bits 3:2 positive, 1:0 negative hysteresis
// - Hysteresis codes off, 5, 10, 20 mV
// - Response time held and driven out
// - Input selects held and driven out
module cmp_ctrl
    import cmp_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [cmp_ctrl_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [cmp_ctrl_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [cmp_ctrl_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic cmp_raw_in,
    output logic comparator_on,
    output cmp_ctrl_pkg::hyst_type pos_hysteresis_sel,
    output cmp_ctrl_pkg::hyst_type neg_hysteresis_sel,
    output logic [1:0] response_time,
    output logic [3:0] pos_input_sel,
    output logic [3:0] neg_input_sel,
    output logic latched_cmp_out,
    output logic raw_cmp_out,
    output logic irq
);
    import cmp_ctrl_pkg::*;

    // Byte addresses of each register
    localparam logic [ADDR_W-1:0] CTL_ADDR = {CTL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] MODE_ADDR = {MODE_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] MUX_ADDR = {MUX_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] MASK_ADDR = {MASK_IDX, 2'b00};

    // Register state
    logic [7:0] ctl_r; // Enable and hysteresis; flags live in their own flops
    logic rise_flag_r; // Sticky rising edge seen
    logic fall_flag_r; // Sticky falling edge seen
    logic [1:0] mode_r; // Response time selection
    logic [7:0] mux_r; // Input selections
    logic [1:0] mask_r; // Bit 1 rise mask, bit 0 fall mask
    logic prev_r; // Synced level one clock earlier
    logic latched_r; // Pin copy of the synced level
    logic irq_r; // Interrupt request flop
    bus_state_type state_r; // Bus answer state
    logic [7:0] rdata_r; // Read data byte
    logic wait_r; // Waitrequest flop

    // Synchronised comparator level
    sync_if sync_bus ();
    logic level_sync; // Result after the two-flop chain

    assign sync_bus.d = cmp_raw_in;
    assign level_sync = sync_bus.q;

    cmp_sync #(
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .s(sync_bus)
    );

    // Bus decoding
    wire logic req = read | write;
    wire logic commit = req & (state_r == BUS_ANSWER);
    wire logic wr_ok = commit & write & byteenable[0];
    wire logic hit_ctl = (address == CTL_ADDR);
    wire logic hit_mode = (address == MODE_ADDR);
    wire logic hit_mux = (address == MUX_ADDR);
    wire logic hit_stat = (address == STAT_ADDR);
    wire logic hit_mask = (address == MASK_ADDR);
    wire logic ctl_wr = wr_ok & hit_ctl;
    wire logic mode_wr = wr_ok & hit_mode;
    wire logic mux_wr = wr_ok & hit_mux;
    wire logic stat_wr = wr_ok & hit_stat;
    wire logic mask_wr = wr_ok & hit_mask;

    // Edge events from the synced level
    wire logic rise_evt = level_sync & ~prev_r;
    wire logic fall_evt = ~level_sync & prev_r;

    // Flag next values: event set beats any write or clear
    wire logic rise_clr = stat_wr & writedata[RISE_BIT];
    wire logic fall_clr = stat_wr & writedata[FALL_BIT];
    wire logic rise_sw = ctl_wr ? writedata[RISE_BIT] : (rise_flag_r & ~rise_clr);
    wire logic fall_sw = ctl_wr ? writedata[FALL_BIT] : (fall_flag_r & ~fall_clr);
    wire logic rise_nxt = rise_evt | rise_sw;
    wire logic fall_nxt = fall_evt | fall_sw;

    // Interrupt request from flags and masks
    wire logic irq_nxt = (rise_nxt & mask_r[1]) | (fall_nxt & mask_r[0]);

    // Readable views
    wire logic [7:0] ctl_view = {ctl_r[EN_BIT], level_sync, rise_flag_r, fall_flag_r,
                                 ctl_r[3:0]};
    wire logic [7:0] stat_view = {2'b00, rise_flag_r, fall_flag_r, 4'h0};
    wire logic [7:0] mask_view = {2'b00, mask_r, 4'h0};
    wire logic [7:0] rdata_nxt =
        hit_ctl ? ctl_view :
        hit_mode ? {6'h00, mode_r} :
        hit_mux ? mux_r :
        hit_stat ? stat_view :
        hit_mask ? mask_view : 8'h00;

    // Bus handshake: first edge latches data, second edge completes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= BUS_IDLE;
            wait_r <= 1'b1;
            rdata_r <= 8'h00;
        end else begin
            case (state_r)
                BUS_IDLE: begin
                    if (req) begin
                        state_r <= BUS_ANSWER;
                        wait_r <= 1'b0;
                        rdata_r <= rdata_nxt;
                    end
                end
                BUS_ANSWER: begin
                    state_r <= BUS_IDLE;
                    wait_r <= 1'b1;
                end
                default: begin
                    state_r <= BUS_IDLE;
                    wait_r <= 1'b1;
                end
            endcase
        end
    end

    // Software-written configuration
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r <= CTL_RST;
            mode_r <= MODE_RST;
            mux_r <= MUX_RST;
            mask_r <= MASK_RST;
        end else begin
            if (ctl_wr) begin
                ctl_r <= {writedata[EN_BIT], 3'b000, writedata[3:0]};
            end
            if (mode_wr) begin
                mode_r <= writedata[1:0];
            end
            if (mux_wr) begin
                mux_r <= writedata[7:0];
            end
            if (mask_wr) begin
                mask_r <= writedata[RISE_BIT:FALL_BIT];
            end
        end
    end

    // Edge tracking, flags, pin copy and interrupt
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
            rise_flag_r <= 1'b0;
            fall_flag_r <= 1'b0;
            latched_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            prev_r <= level_sync;
            rise_flag_r <= rise_nxt;
            fall_flag_r <= fall_nxt;
            latched_r <= level_sync & ctl_r[EN_BIT];
            irq_r <= irq_nxt;
        end
    end

    // Output drive
    assign readdata = {24'h000000, rdata_r};
    assign waitrequest = wait_r;
    assign comparator_on = ctl_r[EN_BIT];
    assign pos_hysteresis_sel = hyst_type'(ctl_r[HYP_LSB+:2]);
    assign neg_hysteresis_sel = hyst_type'(ctl_r[HYN_LSB+:2]);
    assign response_time = mode_r;
    assign pos_input_sel = mux_r[POS_SEL_LSB+:4];
    assign neg_input_sel = mux_r[NEG_SEL_LSB+:4];
    assign latched_cmp_out = latched_r;
    // Raw path must work without a clock, so it is only gated by the enable
    assign raw_cmp_out = cmp_raw_in & ctl_r[EN_BIT];
    assign irq = irq_r;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Enable write reaches the analog core next cycle
    property p_enable;
        ctl_wr |=> comparator_on == $past(writedata[EN_BIT]);
    endproperty
    a_enable: assert property (p_enable) else $error("enable not applied");

    // Control read returns the synced result
    property p_result;
        (state_r == BUS_IDLE && read && hit_ctl) |=> readdata[OUT_BIT] == $past(level_sync);
    endproperty
    a_result: assert property (p_result) else $error("result bit wrong");

    // Falling edge sets its flag
    property p_fall_set;
        (prev_r && !level_sync) |=> fall_flag_r;
    endproperty
    a_fall_set: assert property (p_fall_set) else $error("fall flag missed");

    // Rising edge sets its flag, even under a clear
    property p_rise_set;
        (!prev_r && level_sync) |=> rise_flag_r;
    endproperty
    a_rise_set: assert property (p_rise_set) else $error("rise flag lost");

    // Rise flag holds without software action
    property p_sticky;
        (rise_flag_r && !ctl_wr && !stat_wr) |=> rise_flag_r;
    endproperty
    a_sticky: assert property (p_sticky) else $error("rise flag dropped");

    // Fall flag holds as well without software action
    property p_fall_sticky;
        (fall_flag_r && !ctl_wr && !stat_wr) |=> fall_flag_r;
    endproperty
    a_fall_sticky: assert property (p_fall_sticky) else $error("fall flag dropped");

    // No interrupt with both masks clear
    property p_masked;
        (mask_r == 2'b00) [*2] |-> !irq;
    endproperty
    a_masked: assert property (p_masked) else $error("masked interrupt");

    // Interrupt follows the flags and the masks of one clock earlier
    property p_irq;
        irq == ((rise_flag_r & $past(mask_r[1])) | (fall_flag_r & $past(mask_r[0])));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch");

    // Rise flag with its mask raises the interrupt
    property p_rise_irq;
        (rise_flag_r && $past(mask_r[1])) |-> irq;
    endproperty
    a_rise_irq: assert property (p_rise_irq) else $error("rise interrupt missing");

    // Fall flag with its mask raises the interrupt
    property p_fall_irq;
        (fall_flag_r && $past(mask_r[0])) |-> irq;
    endproperty
    a_fall_irq: assert property (p_fall_irq) else $error("fall interrupt missing");

    // Disabled comparator keeps pin outputs low
    property p_off_low;
        !comparator_on [*2] |-> (!latched_cmp_out && !raw_cmp_out);
    endproperty
    a_off_low: assert property (p_off_low) else $error("pin high while off");

    // Enabled pin copy follows the synced level one clock later
    property p_latched;
        comparator_on |=> latched_cmp_out == $past(level_sync);
    endproperty
    a_latched: assert property (p_latched) else $error("latched copy wrong");

    // Positive hysteresis write reaches the core
    property p_hyst;
        ctl_wr |=> pos_hysteresis_sel == hyst_type'($past(writedata[3:2]));
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis not applied");

    // Mode and mux writes reach the core
    property p_mode;
        mode_wr |=> response_time == $past(writedata[1:0]);
    endproperty
    a_mode: assert property (p_mode) else $error("response time not applied");

    property p_mux;
        mux_wr |=> {neg_input_sel, pos_input_sel} == $past(writedata[7:0]);
    endproperty
    a_mux: assert property (p_mux) else $error("input select not applied");

    // Control write stores flag value when no edge
    property p_flag_store;
        (ctl_wr && !rise_evt) |=> rise_flag_r == $past(writedata[RISE_BIT]);
    endproperty
    a_flag_store: assert property (p_flag_store) else $error("flag write lost");
endmodule // cmp_ctrl
`default_nettype wire

// >>> verif/cmp_core_model.sv
// Purpose: Stand-in for the analog comparator core driving the raw result.
// Assumes: Bench commands the wanted comparison outcome as a level.
// Notes: Level moves just after a clock edge, like a settled analog output.
`default_nettype none
module cmp_core_model (
    input wire logic clock,
    input wire logic want,
    output logic cmp_raw_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Output low until the first edge
    initial cmp_raw_in = 1'h0;
    // Follow the commanded outcome one edge later
    always @(posedge clock) begin
        cmp_raw_in <= want;
    end
endmodule // cmp_core_model
`default_nettype wire

// >>> verif/tb_comparator_digital_control.sv
// Purpose: Self-checking bench for the comparator control block.
// Assumes: Avalon-MM master with waitrequest; one clock at 100 MHz.
// Notes: Register rows first, then edges, masks, gating and reset.
`default_nettype none
module tb_comparator_digital_control
    import cmp_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [7:0] idx; // Register index
        logic [7:0] wd; // Written value
        logic [7:0] rd; // Expected read back
        logic [14:0] o; // Expected core outputs
    } row_type;
    logic clock, rst_n, read, write, want; // Driven by bench
    logic [ADDR_W-1:0] address; // Byte address
    logic [DATA_W-1:0] writedata, readdata; // Bus data
    logic [3:0] byteenable; // Lane enables
    logic waitrequest, cmp_raw_in, comparator_on, latched_cmp_out, raw_cmp_out, irq;
    hyst_type pos_hyst, neg_hyst; // Hysteresis outputs
    logic [1:0] response_time; // Response time output
    logic [3:0] pos_input_sel, neg_input_sel; // Input selects
    logic [14:0] ov; // Core outputs packed
    int error_cnt = 0;
    int n_tests = 0;
    row_type rows [10] = '{
        '{CTL_IDX, 8'h80, 8'h80, 15'h42FF}, '{CTL_IDX, 8'h85, 8'h85, 15'h56FF},
        '{CTL_IDX, 8'h8A, 8'h8A, 15'h6AFF}, '{CTL_IDX, 8'h8F, 8'h8F, 15'h7EFF},
        '{CTL_IDX, 8'h0C, 8'h0C, 15'h32FF}, '{MODE_IDX, 8'h01, 8'h01, 15'h31FF},
        '{MODE_IDX, 8'h03, 8'h03, 15'h33FF}, '{MUX_IDX, 8'h5A, 8'h5A, 15'h33A5},
        '{MASK_IDX, 8'h30, 8'h30, 15'h33A5}, '{8'h10, 8'hFF, 8'h00, 15'h33A5}};
    assign ov = {comparator_on, pos_hyst, neg_hyst, response_time, pos_input_sel, neg_input_sel};
    cmp_ctrl uut (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .cmp_raw_in(cmp_raw_in),
        .comparator_on(comparator_on), .pos_hysteresis_sel(pos_hyst),
        .neg_hysteresis_sel(neg_hyst), .response_time(response_time),
        .pos_input_sel(pos_input_sel), .neg_input_sel(neg_input_sel),
        .latched_cmp_out(latched_cmp_out), .raw_cmp_out(raw_cmp_out), .irq(irq));
    cmp_core_model core (.clock(clock), .want(want), .cmp_raw_in(cmp_raw_in));
    // Clock at 10 ns period
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    // Counts and verdict
    task automatic test_done;
        $display("Checks %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Compare one register read
    task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    // Compare the packed core outputs
    task automatic check_ov(input logic [14:0] got, input logic [14:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: outputs %h expected %h", $time, got, exp);
        end
    endtask
    // Compare one pin level
    task automatic check_pin(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: pin %b expected %b", $time, got, exp);
        end
    endtask
    // One bus cycle, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic is_wr, input logic [7:0] idx, input logic [7:0] wd,
        output logic [7:0] rd);
        @(posedge clock);
        address <= {idx, 2'h0};
        writedata <= {24'h000000, wd};
        read <= !is_wr;
        write <= is_wr;
        // Waitrequest low ends this wait; no timeout besides the watchdog
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'h0);
        // Data taken and request released at the answering edge
        rd = readdata[7:0];
        read <= 1'h0;
        write <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        bus(1'h1, idx, d, r);
    endtask
    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        bus(1'h0, idx, 8'h00, r);
        check_rd(r, exp);
    endtask
    // Move the analog level and follow it through the synchroniser
    task automatic edge_to(input logic v, input logic en);
        @(posedge clock);
        want <= v;
        @(posedge clock);
        #1;
        check_pin(raw_cmp_out, v & en);
        repeat (2) @(posedge clock);
        #1;
        check_pin(latched_cmp_out, !v & en);
        @(posedge clock);
        #1;
        check_pin(latched_cmp_out, v & en);
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        test_done;
    end
    // Main sequence
    initial begin
        rst_n = 1'h0;
        read = 1'h0;
        write = 1'h0;
        want = 1'h0;
        address = '0;
        writedata = '0;
        byteenable = 4'hF;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        check_ov(ov, 15'h02FF);
        // Register rows
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wd);
            rc(rows[i].idx, rows[i].rd);
            check_ov(ov, rows[i].o);
        end
        // Rising edge with both masks on
        wr(CTL_IDX, 8'h80);
        wr(STAT_IDX, 8'h30);
        edge_to(1'h1, 1'h1);
        check_pin(irq, 1'h1);
        rc(CTL_IDX, 8'hE0);
        wr(STAT_IDX, 8'h20);
        rc(STAT_IDX, 8'h00);
        check_pin(irq, 1'h0);
        // Falling edge, then masks off
        wr(MASK_IDX, 8'h10);
        edge_to(1'h0, 1'h1);
        check_pin(irq, 1'h1);
        wr(MASK_IDX, 8'h00);
        rc(STAT_IDX, 8'h10);
        check_pin(irq, 1'h0);
        edge_to(1'h1, 1'h1);
        rc(STAT_IDX, 8'h30);
        check_pin(irq, 1'h0);
        wr(MASK_IDX, 8'h20);
        rc(MASK_IDX, 8'h20);
        check_pin(irq, 1'h1);
        // Flag writes through control
        wr(CTL_IDX, 8'h80);
        rc(CTL_IDX, 8'hC0);
        check_pin(irq, 1'h0);
        wr(CTL_IDX, 8'hB0);
        rc(CTL_IDX, 8'hF0);
        check_pin(irq, 1'h1);
        // Disabled: pins low, result still readable, flags written as zero
        wr(CTL_IDX, 8'h00);
        rc(CTL_IDX, 8'h40);
        check_pin(comparator_on, 1'h0);
        check_pin(raw_cmp_out, 1'h0);
        check_pin(latched_cmp_out, 1'h0);
        // Edges still flagged from the ungated synced level
        edge_to(1'h0, 1'h0);
        rc(STAT_IDX, 8'h10);
        // Write with the low byte lane off is ignored
        byteenable <= 4'hE;
        wr(MODE_IDX, 8'h00);
        byteenable <= 4'hF;
        rc(MODE_IDX, 8'h03);
        // Reset in mid-run
        want <= 1'h0;
        repeat (5) @(posedge clock);
        rst_n <= 1'h0;
        @(negedge clock);
        check_ov(ov, 15'h02FF);
        check_pin(irq, 1'h0);
        check_pin(waitrequest, 1'h1);
        check_rd(readdata[7:0], 8'h00);
        @(posedge clock);
        rst_n <= 1'h1;
        rc(CTL_IDX, 8'h00);
        rc(MODE_IDX, 8'h02);
        rc(MUX_IDX, 8'hFF);
        rc(STAT_IDX, 8'h00);
        rc(MASK_IDX, 8'h00);
        test_done;
    end
endmodule // tb_comparator_digital_control
`default_nettype wire
